// ==== temp_alert_config_logic.sv ====
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Bit 7 sets alarm one active level.
// - Bit 6 flags result above high limit.
// - Window mode bit 5 flags result below low.
// - Hysteresis mode: low flag reads zero.
// - Bit 4 zero: window compare, both flags.
// - Window flags stick until configuration read.
// - Bit 4 one: set above high, clear below low.
// - Hysteresis flags change only at conversion end.
// - Bit 3 sets alarm two active level.
// - Writing one to bit 1 resets all.
// - Period code selects continuous conversion interval.
// - Period code never delays a single conversion.
module temp_alert_config_logic
    import temp_alert_pkg::*;
#(
    parameter period_tbl_t CONV_CYCLES = period_table()
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic [13:0] conv_result,
    input wire logic alarm_one_active,
    output logic conv_start,
    output logic alarm_out_one,
    output logic alarm_out_two,
    output logic irq
);

    logic [15:0] config_r;
    logic [15:0] high_two_r;
    logic [15:0] low_two_r;
    logic [13:0] result_r;
    logic upper_flag_two_r;
    logic lower_flag_two_r;
    logic [IRQ_BITS-1:0] irq_status_r;
    logic [IRQ_BITS-1:0] irq_mask_r;
    logic [IRQ_BITS-1:0] irq_event;
    logic soft_rst_r;
    logic [31:0] period_cnt_r;
    conv_state_e conv_state_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic conv_start_r;
    logic alarm_out_one_r;
    logic alarm_out_two_r;
    logic irq_r;
    logic [31:0] rdata_nxt;
    logic mapped;
    logic wr_en;
    logic rd_en;
    logic cfg_read;
    logic one_shot_req;
    logic period_hit;
    logic above_high;
    logic below_low;
    logic hysteresis_two;
    logic lower_two_visible;
    logic upper_two_nxt;
    logic lower_two_nxt;

    // Pin level for an alarm given its active state and polarity bit
    function automatic logic drive_level(input logic active, input logic active_high);
        return active ? active_high : ~active_high;
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr == OFF_CONFIG || addr == OFF_HIGH_TWO || addr == OFF_LOW_TWO ||
               addr == OFF_RESULT || addr == OFF_IRQ_STATUS || addr == OFF_IRQ_MASK;
    endfunction

    // One wait state: the reply is registered so every bus output comes from a flip-flop
    assign mapped = is_mapped(paddr);
    assign wr_en = psel && penable && pready_r && pwrite && mapped && (pstrb[1:0] == 2'b11);
    // Read side effects land on the edge that captures read data, so a flag set after
    // the capture survives to the next read instead of being cleared unseen
    assign rd_en = psel && penable && !pready_r && !pwrite;
    assign cfg_read = rd_en && paddr == OFF_CONFIG;
    assign hysteresis_two = config_r[MODE_TWO_BIT];
    assign lower_two_visible = lower_flag_two_r && !hysteresis_two;
    assign one_shot_req = wr_en && paddr == OFF_CONFIG && pwdata[ONE_SHOT_BIT]
                          && config_r[SHUTDOWN_BIT];
    assign period_hit = period_cnt_r >= CONV_CYCLES[config_r[15:PERIOD_LSB]] - 32'h1;

    // Limits hold the result in bits 15:2 as two's complement
    assign above_high = $signed(conv_result) > $signed(high_two_r[15:2]);
    assign below_low = $signed(conv_result) < $signed(low_two_r[15:2]);

    always_comb
    begin
        rdata_nxt = 32'h0;
        case (paddr)
            OFF_CONFIG:
            begin
                rdata_nxt[15:0] = config_r & CONFIG_STORE_MASK & ~(16'h1 << ONE_SHOT_BIT);
                rdata_nxt[UPPER_TWO_BIT] = upper_flag_two_r;
                rdata_nxt[LOWER_TWO_BIT] = lower_two_visible;
            end
            OFF_HIGH_TWO: rdata_nxt[15:0] = high_two_r;
            OFF_LOW_TWO: rdata_nxt[15:0] = low_two_r;
            OFF_RESULT: rdata_nxt[15:0] = {result_r, 2'b00};
            OFF_IRQ_STATUS: rdata_nxt[IRQ_BITS-1:0] = irq_status_r;
            OFF_IRQ_MASK: rdata_nxt[IRQ_BITS-1:0] = irq_mask_r;
            default: rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else if (ce)
        begin
            if (psel && penable && !pready_r)
            begin
                pready_r <= 1'b1;
                pslverr_r <= !mapped;
                prdata_r <= (pwrite || !mapped) ? 32'h0 : rdata_nxt;
            end
            else
            begin
                pready_r <= 1'b0;
                pslverr_r <= 1'b0;
            end
        end
    end

    // A write of one to the reset bit takes effect one cycle later, after the bus reply
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_rst_r <= 1'b0;
        else if (ce)
            soft_rst_r <= wr_en && paddr == OFF_CONFIG && pwdata[SOFT_RESET_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            config_r <= CONFIG_RESET;
            high_two_r <= HIGH_TWO_RESET;
            low_two_r <= LOW_TWO_RESET;
            irq_mask_r <= '0;
        end
        else if (ce)
        begin
            if (soft_rst_r)
            begin
                config_r <= CONFIG_RESET;
                high_two_r <= HIGH_TWO_RESET;
                low_two_r <= LOW_TWO_RESET;
                irq_mask_r <= '0;
            end
            else if (wr_en)
            begin
                case (paddr)
                    OFF_CONFIG: config_r <= pwdata[15:0] & CONFIG_STORE_MASK;
                    OFF_HIGH_TWO: high_two_r <= pwdata[15:0] & LIMIT_MASK;
                    OFF_LOW_TWO: low_two_r <= pwdata[15:0] & LIMIT_MASK;
                    OFF_IRQ_MASK: irq_mask_r <= pwdata[IRQ_BITS-1:0];
                    default: config_r <= config_r;
                endcase
            end
        end
    end

    // Continuous timer is free of the one-shot path, so a single request never waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_state_r <= conv_idle;
            period_cnt_r <= 32'h0;
            conv_start_r <= 1'b0;
        end
        else if (ce)
        begin
            conv_start_r <= 1'b0;
            if (soft_rst_r)
            begin
                conv_state_r <= conv_idle;
                period_cnt_r <= 32'h0;
            end
            else
            begin
                if (config_r[SHUTDOWN_BIT] || period_hit)
                    period_cnt_r <= 32'h0;
                else
                    period_cnt_r <= period_cnt_r + 32'h1;
                case (conv_state_r)
                    conv_idle:
                    begin
                        if (one_shot_req)
                        begin
                            conv_start_r <= 1'b1;
                            conv_state_r <= conv_busy;
                        end
                        else if (!config_r[SHUTDOWN_BIT] && period_hit)
                        begin
                            conv_start_r <= 1'b1;
                            conv_state_r <= conv_busy;
                        end
                    end
                    conv_busy:
                    begin
                        if (conv_done)
                            conv_state_r <= conv_idle;
                    end
                    default: conv_state_r <= conv_idle;
                endcase
            end
        end
    end

    always_comb
    begin
        upper_two_nxt = upper_flag_two_r;
        lower_two_nxt = lower_flag_two_r;
        if (hysteresis_two)
        begin
            lower_two_nxt = 1'b0;
            if (conv_done)
            begin
                if (above_high)
                    upper_two_nxt = 1'b1;
                else if (below_low)
                    upper_two_nxt = 1'b0;
            end
        end
        else
        begin
            // A fresh crossing in the clearing read's cycle survives the read
            if (cfg_read)
            begin
                upper_two_nxt = 1'b0;
                lower_two_nxt = 1'b0;
            end
            if (conv_done && above_high)
                upper_two_nxt = 1'b1;
            if (conv_done && below_low)
                lower_two_nxt = 1'b1;
        end
    end

    // Flags in hysteresis mode ignore reads and move only with conversion results
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upper_flag_two_r <= 1'b0;
            lower_flag_two_r <= 1'b0;
            result_r <= 14'h0;
        end
        else if (ce)
        begin
            if (soft_rst_r)
            begin
                upper_flag_two_r <= 1'b0;
                lower_flag_two_r <= 1'b0;
                result_r <= 14'h0;
            end
            else
            begin
                upper_flag_two_r <= upper_two_nxt;
                lower_flag_two_r <= lower_two_nxt;
                if (conv_done)
                    result_r <= conv_result;
            end
        end
    end

    assign irq_event[IRQ_CONV_DONE] = conv_done;
    assign irq_event[IRQ_UPPER_TWO] = upper_two_nxt && !upper_flag_two_r;
    assign irq_event[IRQ_LOWER_TWO] = lower_two_nxt && !lower_flag_two_r;

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_r <= '0;
        else if (ce)
        begin
            if (soft_rst_r)
                irq_status_r <= '0;
            else
            begin
                for (int i = 0; i < IRQ_BITS; i++)
                begin
                    if (irq_event[i])
                        irq_status_r[i] <= 1'b1;
                    else if (wr_en && paddr == OFF_IRQ_STATUS && pwdata[i])
                        irq_status_r[i] <= 1'b0;
                end
            end
        end
    end

    // Pins reset to the inactive level of the reset polarity, active low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_out_one_r <= 1'b1;
            alarm_out_two_r <= 1'b1;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            alarm_out_one_r <= drive_level(alarm_one_active, config_r[LEVEL_ONE_BIT]);
            alarm_out_two_r <= drive_level(upper_flag_two_r || lower_two_visible,
                                           config_r[LEVEL_TWO_BIT]);
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign conv_start = conv_start_r;
    assign alarm_out_one = alarm_out_one_r;
    assign alarm_out_two = alarm_out_two_r;
    assign irq = irq_r;

endmodule

// ==== temp_alert_pkg.sv ====
package temp_alert_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_HIGH_TWO = 8'h04;
    localparam logic [7:0] OFF_LOW_TWO = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // Configuration field positions
    localparam int PERIOD_LSB = 13;
    localparam int ONE_SHOT_BIT = 12;
    localparam int SHUTDOWN_BIT = 11;
    localparam int MODE_ONE_BIT = 8;
    localparam int LEVEL_ONE_BIT = 7;
    localparam int UPPER_TWO_BIT = 6;
    localparam int LOWER_TWO_BIT = 5;
    localparam int MODE_TWO_BIT = 4;
    localparam int LEVEL_TWO_BIT = 3;
    localparam int SOFT_RESET_BIT = 1;

    // Reset values and the bits that software can store
    localparam logic [15:0] CONFIG_RESET = 16'ha000;
    localparam logic [15:0] CONFIG_STORE_MASK = 16'he999;
    localparam logic [15:0] HIGH_TWO_RESET = 16'h7ffc;
    localparam logic [15:0] LOW_TWO_RESET = 16'h8000;
    localparam logic [15:0] LIMIT_MASK = 16'hfffc;

    // Interrupt status bit positions
    localparam int IRQ_BITS = 3;
    localparam int IRQ_CONV_DONE = 0;
    localparam int IRQ_UPPER_TWO = 1;
    localparam int IRQ_LOWER_TWO = 2;

    // Conversion periods per code, in milliseconds
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CONV_PERIOD_MS [8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};

    typedef logic [31:0] period_tbl_t [8];

    function automatic period_tbl_t period_table();
        period_tbl_t t;
        for (int i = 0; i < 8; i++)
        begin
            t[i] = 32'(CONV_PERIOD_MS[i] * CYCLES_PER_MS);
        end
        return t;
    endfunction

    typedef enum logic [0:0] {conv_idle, conv_busy} conv_state_e;

endpackage

// ==== adc_model.sv ====
`timescale 1ns/10ps
module adc_model(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic slow,
    input wire logic [13:0] temp,
    output logic conv_done,
    output logic [13:0] conv_result
);
    logic [2:0] wait_r;
    // Outside the done strobe the result lines carry the inverse, so a stale sample shows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r <= 3'h0;
            conv_done <= 1'b0;
            conv_result <= 14'h0;
        end
        else
        begin
            conv_done <= wait_r == 3'h1;
            conv_result <= wait_r == 3'h1 ? temp : ~temp;
            if (conv_start)
                wait_r <= slow ? 3'h6 : 3'h1;
            else if (wait_r != 3'h0)
                wait_r <= wait_r - 3'h1;
        end
    end
endmodule

// ==== temp_alert_checker.sv ====
`timescale 1ns/10ps
module temp_alert_checker(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_done,
    input wire logic alarm_one_active,
    input wire logic conv_start,
    input wire logic alarm_out_one,
    input wire logic alarm_out_two,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_wait:
    assert property (ce && psel && !penable ##1 psel && penable |=> pready)
        else $error("no ready in second access cycle");
    chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
    chk_err_map:
    assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h14))
        else $error("wrong error response");
    chk_data_zero:
    assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("read data not zero");
    chk_start_pulse:
    assert property (conv_start |=> !conv_start) else $error("start pulse too long");
    chk_busy_hold:
    assert property (conv_start |=> !conv_start until conv_done) else $error("start while busy");
    chk_level_one:
    assert property ($changed(alarm_one_active) && !pready && !$past(pready)
        && !$past(pready, 2) |=> $changed(alarm_out_one)) else $error("alarm one not following");
    chk_two_cause:
    assert property ($changed(alarm_out_two) |-> $past(conv_done) || $past(conv_done, 2)
        || $past(pready) || $past(pready, 2) || $past(pready, 3))
        else $error("alarm two changed without cause");
    chk_irq_cause:
    assert property ($changed(irq) |-> $past(conv_done) || $past(conv_done, 2)
        || $past(conv_done, 3) || $past(pready) || $past(pready, 2) || $past(pready, 3))
        else $error("irq changed without cause");
endmodule
bind temp_alert_config_logic temp_alert_checker chk_inst(.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .conv_done, .alarm_one_active, .conv_start,
    .alarm_out_one, .alarm_out_two, .irq);

// ==== temp_alert_config_logic_bench.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module temp_alert_config_logic_bench;
    import temp_alert_pkg::*;
    localparam period_tbl_t CYC = '{8, 10, 12, 14, 16, 20, 24, 28};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alarm_one_active = 0, slow = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [13:0] temp = 0, conv_result;
    logic pready, pslverr, conv_done, conv_start, alarm_out_one, alarm_out_two, irq;
    logic [32:0] expv, q[$];
    logic [15:0] c;
    int mismatches = 0, checks_done = 0, seed = 29, cycles = 0, n;
    temp_alert_config_logic #(.CONV_CYCLES(CYC)) temp_alert_config_logic_inst(.pclk, .presetn,
        .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .conv_done, .conv_result, .alarm_one_active, .conv_start, .alarm_out_one,
        .alarm_out_two, .irq);
    adc_model adc_model_inst(.pclk, .presetn, .conv_start, .slow, .temp, .conv_done, .conv_result);
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end
    // Reads complete in issue order, so the oldest note always belongs to this answer
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && pwrite === 1'b0)
        begin
            expv = q.pop_front();
            `CHK({pslverr, prdata}, expv)
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        xfer(0, a, 16'h0);
    endtask
    task automatic wait_start();
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (conv_start !== 1'b1);
    endtask
    // One-shot in shutdown mode keeps conversions under the bench's control
    task automatic one(input logic [13:0] t);
        temp <= t;
        xfer(1, OFF_CONFIG, c | 16'h1000);
        wait_start();
        `CHK(n <= 3, 1'b1)
        do @(posedge pclk); while (conv_done !== 1'b1);
        repeat (3) @(posedge pclk);
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        rd(OFF_CONFIG, 33'ha000);
        rd(OFF_HIGH_TWO, 33'h7ffc);
        rd(OFF_LOW_TWO, 33'h8000);
        rd(8'h18, 33'h1_0000_0000);
        `CHK({alarm_out_one, alarm_out_two}, 2'b11)
        pstrb <= 4'h1;
        xfer(1, OFF_IRQ_MASK, 16'h6);
        pstrb <= 4'hf;
        rd(OFF_IRQ_MASK, 33'h0);
        xfer(1, OFF_IRQ_MASK, 16'h6);
        $display("test reset done");
        repeat (3) @(posedge pclk);
        alarm_one_active <= 1;
        repeat (2) @(posedge pclk);
        `CHK(alarm_out_one, 1'b0)
        xfer(1, OFF_CONFIG, 16'ha088);
        repeat (2) @(posedge pclk);
        `CHK({alarm_out_one, alarm_out_two}, 2'b10)
        $display("test polarity done");
        c = 16'he800;
        xfer(1, OFF_CONFIG, c);
        xfer(1, OFF_HIGH_TWO, 16'h0190);
        xfer(1, OFF_LOW_TWO, 16'hfe70);
        one(14'd200);
        `CHK({alarm_out_two, irq}, 2'b01)
        rd(OFF_IRQ_STATUS, 33'h3);
        xfer(1, OFF_IRQ_STATUS, 16'h7);
        rd(OFF_CONFIG, {17'h0, c | 16'h0040});
        rd(OFF_CONFIG, {17'h0, c});
        `CHK({alarm_out_two, irq}, 2'b10)
        one(14'h3f38);
        rd(OFF_CONFIG, {17'h0, c | 16'h0020});
        rd(OFF_RESULT, 33'hfce0);
        rd(OFF_IRQ_STATUS, 33'h5);
        for (int i = 0; i < 4; i++)
        begin
            slow <= 1'($random(seed));
            one(14'($random(seed)));
            rd(OFF_RESULT, {17'h0, temp, 2'b00});
        end
        $display("test window done");
        xfer(1, OFF_CONFIG, c | 16'h0002);
        rd(OFF_CONFIG, 33'ha000);
        rd(OFF_HIGH_TWO, 33'h7ffc);
        c = 16'he810;
        xfer(1, OFF_CONFIG, c);
        xfer(1, OFF_HIGH_TWO, 16'h0190);
        xfer(1, OFF_LOW_TWO, 16'hfe70);
        one(14'd200);
        rd(OFF_CONFIG, {17'h0, c | 16'h0040});
        rd(OFF_CONFIG, {17'h0, c | 16'h0040});
        `CHK(alarm_out_two, 1'b0)
        one(14'd0);
        rd(OFF_CONFIG, {17'h0, c | 16'h0040});
        one(14'h3f38);
        rd(OFF_CONFIG, {17'h0, c});
        `CHK(alarm_out_two, 1'b1)
        $display("test hysteresis done");
        slow <= 0;
        for (int k = 0; k < 8; k++)
        begin
            xfer(1, OFF_CONFIG, 16'(k << 13));
            wait_start();
            wait_start();
            wait_start();
            `CHK(32'(n), CYC[k])
        end
        $display("test periods done");
        close_out();
    end
endmodule
